/* src/microstep_wave_spi_output.sv */
// Microstep wave sequencer with AXI4-Lite registers and serial driver link master
//
// Local design decision: the AXI4-Lite register port.
`default_nettype none
// How it works
// - Sine starts at position 0, cosine at 256; start currents 0 and 247.
// - Start currents come from register bits 7:0 and 23:16; positions fixed.
// - Segment select resets to 0xffff8056: border 128, slopes 2 then 1.
// - Next table value adds base slope minus one plus the entry offset bit.
// - The block is link master and drives the serial clock itself.
// - Active-low chip select frames each datagram shifted out on serial data.
// - Driver answers on serial input during the transfer; block samples it.
// - Clock low phase lasts output config bits 23:20 core cycles.
// - Clock high phase lasts output config bits 27:24 core cycles.
// - At least bits 31:28 core cycles pass between two datagrams.
// - Serial clock and chip select stay high in the gap.
// - A timing field below two counts as two cycles.
// - Each ramp step moves the microstep counter up or down by direction.
// - Counter readable; coil currents follow every counter change.
// - With automatic transfer enabled, a current update sends a datagram; updates during one transfer share the next one.
// - Datagram carries polarity and amplitude per coil, length fixed at 18 bits.
// - Microsteps-per-fullstep code scales the counter step, code 2 gives 4.
// - Quarter wave of 256 entries mirrors into a 1024 position period.
// - Currents reload from start values whenever the counter passes zero.
// - Segment select holds borders 31:24, 23:16, 15:8 and four slopes below.
// - Eight offset words hold the 256 bits, lowest entries lowest address.
module microstep_wave_spi_output (
  input  wire logic                            I_CORE_CLK, // Core clock, 20 MHz
  input  wire logic                            I_RST_N,    // Synchronous reset, active low
  input  wire logic [wave_spi_pkg::ADDR_W-1:0] I_AWADDR,   // Write address
  input  wire logic                            I_AWVALID,  // Write address valid
  output var  logic                            O_AWREADY,  // Write address ready
  input  wire logic [31:0]                     I_WDATA,    // Write data
  input  wire logic [3:0]                      I_WSTRB,    // Write byte strobes
  input  wire logic                            I_WVALID,   // Write data valid
  output var  logic                            O_WREADY,   // Write data ready
  output var  logic [1:0]                      O_BRESP,    // Write response
  output var  logic                            O_BVALID,   // Write response valid
  input  wire logic                            I_BREADY,   // Write response ready
  input  wire logic [wave_spi_pkg::ADDR_W-1:0] I_ARADDR,   // Read address
  input  wire logic                            I_ARVALID,  // Read address valid
  output var  logic                            O_ARREADY,  // Read address ready
  output var  logic [31:0]                     O_RDATA,    // Read data
  output var  logic [1:0]                      O_RRESP,    // Read response
  output var  logic                            O_RVALID,   // Read data valid
  input  wire logic                            I_RREADY,   // Read data ready
  input  wire logic                            I_STEP,     // Ramp step pulse
  input  wire logic                            I_DIR,      // Ramp direction, 1 = up
  output var  logic                            O_DRV_SCK,  // Driver serial clock
  output var  logic                            O_DRV_CS_N, // Driver chip select
  output var  logic                            O_DRV_SDO,  // Driver serial out
  input  wire logic                            I_DRV_SDI   // Driver serial in
);
  import wave_spi_pkg::*;

  logic [31:0]        link_cfg, motion_cfg, seg_sel, start_vals;
  logic [31:0]        ofs_word [0:7];
  logic [255:0]       ofs_flat;
  logic [9:0]         ustep_cnt, walk;
  logic               walk_fwd, moved, upd, pending;
  logic signed [8:0]  mag_a, mag_b, cur_a, cur_b;
  link_state_type     state;
  logic [3:0]         tmr;
  logic [4:0]         bits_left;
  logic [17:0]        shreg, rx, drv_resp;
  logic               sdi_s1, sdi_s2;

  // ---------------------------------------------------------------
  // Wave table, link timing and register bus helpers
  // ---------------------------------------------------------------
  function automatic logic signed [2:0] step_inc(input logic [7:0] k);
    logic [1:0] w;
    w = (k >= seg_sel[X3_LSB +: 8]) ? seg_sel[7:6] :
        (k >= seg_sel[X2_LSB +: 8]) ? seg_sel[5:4] :
        (k >= seg_sel[X1_LSB +: 8]) ? seg_sel[3:2] : seg_sel[1:0];
    step_inc = $signed({1'b0, w}) + $signed({2'b00, ofs_flat[k]}) - 3'sd1;
  endfunction

  // Magnitude after one microstep from position p
  function automatic logic signed [8:0] mag_step(input logic signed [8:0] m,
                                                 input logic [9:0] p, input logic fwd);
    logic [9:0] q;
    logic [7:0] k;
    logic signed [8:0] d;
    q = fwd ? p : p - 10'd1;
    k = q[8] ? ~q[7:0] : q[7:0];
    d = 9'(step_inc(k));
    mag_step = (fwd ^ q[8]) ? m + d : m - d;
  endfunction

  function automatic logic [3:0] phase_len(input logic [3:0] f);
    phase_len = (f < MIN_PHASE) ? MIN_PHASE : f;
  endfunction

  function automatic logic [1:0] reg_kind(input logic [ADDR_W-1:0] a);
    logic [6:0] i;
    i = a[8:2];
    if (a[ADDR_W-1:9] != '0)
      reg_kind = 2'h0;
    else if (i == IDX_LINK_CFG || i == IDX_MOTION_CFG || i == IDX_SEG_SEL ||
             i == IDX_START || i[6:3] == IDX_OFS_GROUP)
      reg_kind = 2'h2;
    else if (i == IDX_USTEP_CNT || i == IDX_COIL_A || i == IDX_COIL_B || i == IDX_DRV_RESP)
      reg_kind = 2'h1;
    else
      reg_kind = 2'h0;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      old[8*b +: 8] = s[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
    merge = old;
  endfunction

  for (genvar g = 0; g < 8; g++) begin : g_ofs
    assign ofs_flat[32*g +: 32] = ofs_word[g];
  end

  // ---------------------------------------------------------------
  // Microstep counter and wave walker
  // ---------------------------------------------------------------
  wire [3:0]        mstep_code = motion_cfg[MSTEP_LSB +: 4];
  wire [3:0]        mcode      = (mstep_code > MSTEP_MAX_CODE) ? MSTEP_MAX_CODE : mstep_code;
  wire [9:0]        step_size  = 10'd1 << mcode;
  wire [9:0]        next_cnt   = I_DIR ? ustep_cnt + step_size : ustep_cnt - step_size;
  wire              walk_busy  = (walk != ustep_cnt);
  wire [9:0]        next_walk  = walk_fwd ? walk + 10'd1 : walk - 10'd1;
  wire [9:0]        pos_b      = walk + COS_ORIGIN;
  wire signed [8:0] next_mag_a = mag_step(mag_a, walk, walk_fwd);
  wire signed [8:0] next_mag_b = mag_step(mag_b, pos_b, walk_fwd);
  wire signed [8:0] sine_start = $signed({1'b0, start_vals[SIN_LSB +: 8]});
  wire signed [8:0] cos_start  = $signed({1'b0, start_vals[COS_LSB +: 8]});
  wire signed [8:0] sgn_a      = walk[9] ? -mag_a : mag_a;
  wire signed [8:0] sgn_b      = pos_b[9] ? -mag_b : mag_b;
  wire [8:0]        abs_a      = cur_a[8] ? 9'(-cur_a) : cur_a;
  wire [8:0]        abs_b      = cur_b[8] ? 9'(-cur_b) : cur_b;
  wire [17:0]       frame      = {cur_a[8], abs_a[7:0], cur_b[8], abs_b[7:0]};
  wire              auto_en    = (link_cfg[FMT_LSB +: 4] != 4'h0);

  // The walker moves one entry per core cycle, so coarse steps settle
  // in as many cycles as the step size, up to 256, and the incremental table never skips an entry.
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      ustep_cnt <= SINE_ORIGIN;
      walk      <= SINE_ORIGIN;
      walk_fwd  <= 1'b1;
      moved     <= 1'b0;
      mag_a     <= $signed({1'b0, SINE_START_RST});
      mag_b     <= $signed({1'b0, COS_START_RST});
    end else begin
      if (I_STEP) begin
        ustep_cnt <= next_cnt;
        walk_fwd  <= I_DIR;
      end
      moved <= walk_busy;
      if (walk_busy) begin
        walk <= next_walk;
        if (next_walk == SINE_ORIGIN) begin
          mag_a <= sine_start;
          mag_b <= cos_start;
        end else begin
          mag_a <= next_mag_a;
          mag_b <= next_mag_b;
        end
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      cur_a <= $signed({1'b0, SINE_START_RST});
      cur_b <= $signed({1'b0, COS_START_RST});
      upd   <= 1'b0;
    end else begin
      upd <= moved && !walk_busy;
      if (moved && !walk_busy) begin
        cur_a <= sgn_a;
        cur_b <= sgn_b;
      end
    end
  end

  // ---------------------------------------------------------------
  // Driver link master
  // ---------------------------------------------------------------
  wire start_frame = (state == ST_IDLE) && pending;
  wire next_pending = (upd && auto_en) || (pending && !start_frame);

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      sdi_s1  <= 1'b0;
      sdi_s2  <= 1'b0;
      pending <= 1'b0;
    end else begin
      sdi_s1  <= I_DRV_SDI;
      sdi_s2  <= sdi_s1;
      pending <= next_pending;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      state      <= ST_IDLE;
      tmr        <= 4'h0;
      bits_left  <= 5'd0;
      shreg      <= '0;
      rx         <= '0;
      drv_resp   <= '0;
      O_DRV_SCK  <= 1'b1;
      O_DRV_CS_N <= 1'b1;
      O_DRV_SDO  <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (pending) begin
            O_DRV_CS_N <= 1'b0;
            O_DRV_SCK  <= 1'b0;
            O_DRV_SDO  <= frame[17];
            shreg      <= {frame[16:0], 1'b0};
            bits_left  <= FRAME_BITS - 5'd1;
            tmr        <= phase_len(link_cfg[LOW_LSB +: 4]) - 4'd1;
            state      <= ST_LOW;
          end
        end
        ST_LOW: begin
          tmr <= tmr - 4'd1;
          if (tmr == 4'h0) begin
            O_DRV_SCK <= 1'b1;
            tmr       <= phase_len(link_cfg[HIGH_LSB +: 4]) - 4'd1;
            state     <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          tmr <= tmr - 4'd1;
          // The synchroniser lags two cycles, so the bit that stood across the rise
          // is taken at the end of the high phase; a two-cycle low or high phase is long enough
          if (tmr == 4'h0 && bits_left != 5'd0) begin
            rx        <= {rx[16:0], sdi_s2};
            O_DRV_SCK <= 1'b0;
            O_DRV_SDO <= shreg[17];
            shreg     <= {shreg[16:0], 1'b0};
            bits_left <= bits_left - 5'd1;
            tmr       <= phase_len(link_cfg[LOW_LSB +: 4]) - 4'd1;
            state     <= ST_LOW;
          end else if (tmr == 4'h0) begin
            O_DRV_CS_N <= 1'b1;
            drv_resp   <= {rx[16:0], sdi_s2};
            tmr        <= phase_len(link_cfg[BLOCK_LSB +: 4]) - 4'd1;
            state      <= ST_GAP;
          end
        end
        ST_GAP: begin
          tmr <= tmr - 4'd1;
          if (tmr == 4'h0) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  wire               do_write = !O_AWREADY && !O_WREADY && !O_BVALID;
  wire [6:0]         widx     = awaddr_q[8:2];
  wire               wr_ok    = (reg_kind(awaddr_q) == 2'h2);
  wire [6:0]         ridx     = I_ARADDR[8:2];
  wire [1:0]         rkind    = reg_kind(I_ARADDR);
  wire [31:0]        rd_word  =
    (rkind == 2'h0)          ? 32'h0 :
    (ridx == IDX_LINK_CFG)   ? link_cfg :
    (ridx == IDX_MOTION_CFG) ? motion_cfg :
    (ridx == IDX_DRV_RESP)   ? {14'h0, drv_resp} :
    (ridx == IDX_SEG_SEL)    ? seg_sel :
    (ridx == IDX_USTEP_CNT)  ? {22'h0, ustep_cnt} :
    (ridx == IDX_COIL_A)     ? 32'(cur_a) :
    (ridx == IDX_COIL_B)     ? 32'(cur_b) :
    (ridx == IDX_START)      ? start_vals : ofs_word[ridx[2:0]];

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      O_AWREADY <= 1'b1;
      O_WREADY  <= 1'b1;
      O_BVALID  <= 1'b0;
      O_BRESP   <= RESP_OKAY;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        awaddr_q  <= I_AWADDR;
        O_AWREADY <= 1'b0;
      end
      if (I_WVALID && O_WREADY) begin
        wdata_q  <= I_WDATA;
        wstrb_q  <= I_WSTRB;
        O_WREADY <= 1'b0;
      end
      if (do_write) begin
        O_BVALID <= 1'b1;
        O_BRESP  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (O_BVALID && I_BREADY) begin
        O_BVALID  <= 1'b0;
        O_AWREADY <= 1'b1;
        O_WREADY  <= 1'b1;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      link_cfg   <= LINK_CFG_RST;
      motion_cfg <= MOTION_CFG_RST;
      seg_sel    <= SEG_SEL_RST;
      start_vals <= START_RST;
      for (int n = 0; n < 8; n++) begin
        ofs_word[n] <= 32'h0;
      end
    end else if (do_write && wr_ok) begin
      if (widx == IDX_LINK_CFG) link_cfg <= merge(link_cfg, wdata_q, wstrb_q);
      if (widx == IDX_MOTION_CFG) motion_cfg <= merge(motion_cfg, wdata_q, wstrb_q);
      if (widx == IDX_SEG_SEL) seg_sel <= merge(seg_sel, wdata_q, wstrb_q);
      if (widx == IDX_START) start_vals <= merge(start_vals, wdata_q, wstrb_q);
      if (widx[6:3] == IDX_OFS_GROUP) begin
        ofs_word[widx[2:0]] <= merge(ofs_word[widx[2:0]], wdata_q, wstrb_q);
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      O_ARREADY <= 1'b1;
      O_RVALID  <= 1'b0;
      O_RDATA   <= 32'h0;
      O_RRESP   <= RESP_OKAY;
    end else if (I_ARVALID && O_ARREADY) begin
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b1;
      O_RDATA   <= rd_word;
      O_RRESP   <= (rkind == 2'h0) ? RESP_SLVERR : RESP_OKAY;
    end else if (O_RVALID && I_RREADY) begin
      O_RVALID  <= 1'b0;
      O_ARREADY <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic [4:0] low_run, high_run, gap_run, rise_cnt;
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      low_run  <= 5'd0;
      high_run <= 5'd0;
      gap_run  <= 5'd31;
      rise_cnt <= 5'd0;
    end else begin
      low_run  <= O_DRV_SCK ? 5'd0 : low_run + 5'd1;
      high_run <= (!O_DRV_SCK || O_DRV_CS_N) ? 5'd0 : high_run + 5'd1;
      gap_run  <= !O_DRV_CS_N ? 5'd0 : (gap_run == 5'd31) ? gap_run : gap_run + 5'd1;
      rise_cnt <= O_DRV_CS_N ? 5'd0 : rise_cnt + 5'(!O_DRV_SCK && !low_run[4] && tmr == 4'h0
                                                   && state == ST_LOW);
    end
  end

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);

  a_gap_lines_high: assert property ((state == ST_GAP) |-> O_DRV_SCK && O_DRV_CS_N)
    else $error("clock or select low in gap");
  a_low_phase_len: assert property (($rose(O_DRV_SCK) && !O_DRV_CS_N)
    |-> low_run == 5'(phase_len(link_cfg[LOW_LSB +: 4])))
    else $error("low phase length wrong");
  a_high_phase_len: assert property (($fell(O_DRV_SCK) && $past(!O_DRV_CS_N))
    |-> high_run == 5'(phase_len(link_cfg[HIGH_LSB +: 4])))
    else $error("high phase length wrong");
  a_gap_min_len: assert property ($fell(O_DRV_CS_N)
    |-> gap_run >= 5'(phase_len(link_cfg[BLOCK_LSB +: 4])))
    else $error("gap shorter than block time");
  a_frame_bit_count: assert property ($rose(O_DRV_CS_N) |-> $past(rise_cnt) == FRAME_BITS)
    else $error("datagram bit count wrong");
  a_step_moves_cnt: assert property (I_STEP |=> ustep_cnt ==
    ($past(I_DIR) ? $past(ustep_cnt) + $past(step_size) : $past(ustep_cnt) - $past(step_size)))
    else $error("counter step wrong");
  a_zero_reload: assert property ((walk_busy && next_walk == SINE_ORIGIN)
    |=> mag_a == $past(sine_start) && mag_b == $past(cos_start))
    else $error("no reload at zero");
  a_auto_frame: assert property ((upd && auto_en) |-> ##[1:700] $fell(O_DRV_CS_N))
    else $error("update sent no datagram");
  a_sdo_on_fall: assert property ($changed(O_DRV_SDO) |-> !O_DRV_SCK && !O_DRV_CS_N)
    else $error("data changed outside clock low");
  a_currents_follow: assert property ((moved && !walk_busy) |=> upd && cur_a == $past(sgn_a))
    else $error("current not updated");

  c_frame_done: cover property ($rose(O_DRV_CS_N));
  c_zero_pass: cover property (walk_busy && !walk_fwd && next_walk == SINE_ORIGIN);
  c_coarse_step: cover property (I_STEP && mcode == 4'h2);
endmodule
`default_nettype wire

/* src/wave_spi_pkg.sv */
// Constants and types for the microstep wave sequencer and driver link
`default_nettype none
package wave_spi_pkg;
  // ---------------------------------------------------------------
  // Bus and register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int         ADDR_W         = 12;
  localparam logic [6:0] IDX_LINK_CFG   = 7'h04;
  localparam logic [6:0] IDX_MOTION_CFG = 7'h0a;
  localparam logic [6:0] IDX_DRV_RESP   = 7'h0b;
  localparam logic [3:0] IDX_OFS_GROUP  = 4'he;
  localparam logic [6:0] IDX_SEG_SEL    = 7'h78;
  localparam logic [6:0] IDX_USTEP_CNT  = 7'h79;
  localparam logic [6:0] IDX_COIL_A     = 7'h7a;
  localparam logic [6:0] IDX_COIL_B     = 7'h7b;
  localparam logic [6:0] IDX_START      = 7'h7e;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  SINE_START_RST = 8'h00;
  localparam logic [7:0]  COS_START_RST  = 8'hf7;
  localparam logic [31:0] START_RST      = {8'h00, COS_START_RST, 8'h00, SINE_START_RST};
  localparam logic [31:0] SEG_SEL_RST    = 32'hffff8056;
  localparam logic [31:0] LINK_CFG_RST   = 32'h00000000;
  localparam logic [31:0] MOTION_CFG_RST = 32'h00000000;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int FMT_LSB   = 0;
  localparam int LOW_LSB   = 20;
  localparam int HIGH_LSB  = 24;
  localparam int BLOCK_LSB = 28;
  localparam int MSTEP_LSB = 0;
  localparam int SIN_LSB   = 0;
  localparam int COS_LSB   = 16;
  localparam int X1_LSB    = 8;
  localparam int X2_LSB    = 16;
  localparam int X3_LSB    = 24;
  // ---------------------------------------------------------------
  // Wave positions, counts and link states
  // ---------------------------------------------------------------
  localparam logic [9:0] SINE_ORIGIN    = 10'h000;
  localparam logic [9:0] COS_ORIGIN     = 10'h100;
  localparam logic [3:0] MIN_PHASE      = 4'h2;
  localparam logic [3:0] MSTEP_MAX_CODE = 4'h8;
  localparam logic [4:0] FRAME_BITS     = 5'd18;
  typedef enum {ST_IDLE, ST_LOW, ST_HIGH, ST_GAP} link_state_type;
endpackage
`default_nettype wire

/* tb/drv_slave_model.sv */
// Behavioural motor driver answering on the serial link
`default_nettype none
module drv_slave_model #(
  parameter logic [17:0] RESP = 18'h2b4c6 // Answer returned in every frame
) (
  input  wire logic        i_sck,   // Serial clock from the block
  input  wire logic        i_cs_n,  // Chip select, active low
  input  wire logic        i_sdo,   // Datagram bits from the block
  output var  logic        o_sdi,   // Answer bits to the block
  output var  logic [17:0] o_rx,    // Last datagram taken whole
  output var  int          o_frames // Frames completed
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [17:0] shift_in = 18'h00000;
  int          n_rise   = 0;
  initial begin
    o_sdi = 1'b0;
    o_rx = 18'h00000;
    o_frames = 0;
  end
  // Answer moves just after the falling clock, so it is settled at the rise
  always @(negedge i_sck) begin
    #1;
    if (!i_cs_n && n_rise < 18) o_sdi = RESP[17 - n_rise];
  end
  always @(posedge i_sck) begin
    if (!i_cs_n) begin
      shift_in = {shift_in[16:0], i_sdo};
      n_rise++;
    end
  end
  // Released line shows the inverse of the last bit, never a stale copy
  always @(posedge i_cs_n) begin
    if (n_rise > 0) begin
      o_rx = shift_in;
      o_frames++;
      n_rise = 0;
      o_sdi = ~o_sdi;
    end
  end
endmodule
`default_nettype wire

/* tb/test_microstep_wave_spi_output.sv */
// Self-checking bench for the microstep wave sequencer and its driver link
`default_nettype none
module test_microstep_wave_spi_output;
  timeunit 1ns;
  timeprecision 1ns;
  import wave_spi_pkg::*;
  localparam logic [17:0] RESP = 18'h2b4c6;
  logic [ADDR_W-1:0] awaddr = 12'h000;
  logic [ADDR_W-1:0] araddr = 12'h000;
  logic [31:0]       wdata  = 32'h00000000;
  logic              clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic              arvalid = 1'b0, rready = 1'b0, step = 1'b0, dir = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid, sck, cs_n, sdo, sdi;
  logic [1:0]        bresp, rresp;
  logic [31:0]       rdata;
  logic [17:0]       rx_word;
  logic              psck = 1'b1, pcs = 1'b1, psdo = 1'b0;
  int                frames, n_fail = 0, n_checks = 0, cnt = 0;
  int                exp_low = 2, exp_high = 2, exp_gap = 2;

  initial forever #25 clk = ~clk;

  microstep_wave_spi_output i_microstep_wave_spi_output (
    .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wvalid),
    .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_STEP(step), .I_DIR(dir),
    .O_DRV_SCK(sck), .O_DRV_CS_N(cs_n), .O_DRV_SDO(sdo), .I_DRV_SDI(sdi));
  drv_slave_model #(.RESP(RESP)) i_drv_slave_model (
    .i_sck(sck), .i_cs_n(cs_n), .i_sdo(sdo), .o_sdi(sdi), .o_rx(rx_word), .o_frames(frames));

  // ---------------------------------------------------------------
  // Comparison, bus and step tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic lost(input string what);
    chk(32'h0, 32'h1, what);
    final_report();
  endtask
  task automatic wr(input logic [6:0] idx, input logic [31:0] d, input logic [1:0] er);
    int n;
    awaddr <= {3'h0, idx, 2'h0};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50 && !bvalid; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    if (!bvalid) lost("write hang");
    chk({30'h0, bresp}, {30'h0, er}, "bresp");
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [6:0] idx, input logic [31:0] ed, input logic [1:0] er);
    int n;
    araddr <= {3'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50 && !rvalid; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    if (!rvalid) lost("read hang");
    chk(rdata, ed, "rdata");
    chk({30'h0, rresp}, {30'h0, er}, "rresp");
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic stp(input logic d);
    step <= 1'b1;
    dir <= d;
    @(posedge clk);
    step <= 1'b0;
  endtask
  task automatic wait_frames(input int n);
    int k;
    for (k = 0; k < 3000 && frames < n; k++) @(posedge clk);
    if (frames < n) lost("no frame");
  endtask

  // Phase lengths are counted in core cycles between changes of clock or select
  always @(posedge clk) begin
    if (rst_n) begin
      chk({31'h0, cs_n && !sck}, 32'h0, "idle clock");
      chk({31'h0, pcs || cs_n || sdo === psdo || (psck && !sck)}, 32'h1, "data edge");
      if (sck !== psck || cs_n !== pcs) begin
        if (!pcs) chk(32'(cnt), 32'(psck ? exp_high : exp_low), "phase");
        if (pcs) chk({31'h0, cnt >= exp_gap}, 32'h1, "gap");
        cnt = 1;
      end else cnt++;
    end
    psck = sck;
    pcs = cs_n;
    psdo = sdo;
  end

  initial begin
    int i, k;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(IDX_SEG_SEL, 32'hffff8056, RESP_OKAY);
    rd(IDX_START, 32'h00f70000, RESP_OKAY);
    rd(IDX_USTEP_CNT, 32'h00000000, RESP_OKAY);
    rd(IDX_COIL_A, 32'h00000000, RESP_OKAY);
    rd(IDX_COIL_B, 32'h000000f7, RESP_OKAY);
    rd(7'h05, 32'h00000000, RESP_SLVERR);
    wr(IDX_USTEP_CNT, 32'h00000005, RESP_SLVERR);
    wr({IDX_OFS_GROUP, 3'h0}, 32'hffffffff, RESP_OKAY);
    wr(IDX_MOTION_CFG, 32'h00000002, RESP_OKAY);
    exp_low = 3;
    exp_high = 4;
    exp_gap = 5;
    wr(IDX_LINK_CFG, 32'h54300001, RESP_OKAY);
    stp(1'b1);
    wait_frames(1);
    rd(IDX_USTEP_CNT, 32'h00000004, RESP_OKAY);
    rd(IDX_COIL_A, 32'h00000008, RESP_OKAY);
    chk({23'h0, rx_word[17:9]}, 32'h00000008, "datagram");
    rd(IDX_DRV_RESP, {14'h0, RESP}, RESP_OKAY);
    // Third step lands inside the second frame, so its datagram must wait out the gap
    stp(1'b0);
    for (k = 0; k < 3000 && cs_n; k++) @(posedge clk);
    stp(1'b0);
    wait_frames(3);
    rd(IDX_USTEP_CNT, 32'h000003fc, RESP_OKAY);
    rd(IDX_COIL_A, 32'hfffffff8, RESP_OKAY);
    chk({23'h0, rx_word[17:9]}, 32'h00000108, "datagram");
    exp_low = 2;
    exp_high = 2;
    exp_gap = 2;
    wr(IDX_LINK_CFG, 32'h00000001, RESP_OKAY);
    wr(IDX_MOTION_CFG, 32'h00000000, RESP_OKAY);
    wr({IDX_OFS_GROUP, 3'h0}, 32'h00000000, RESP_OKAY);
    wr(IDX_SEG_SEL, 32'hffff8054, RESP_OKAY);
    wr(IDX_START, 32'h00f70005, RESP_OKAY);
    for (i = 0; i < 7; i++) begin
      stp(1'b1);
      wait_frames(4 + i);
    end
    rd(IDX_USTEP_CNT, 32'h00000003, RESP_OKAY);
    rd(IDX_COIL_A, 32'h00000002, RESP_OKAY);
    chk({23'h0, rx_word[17:9]}, 32'h00000002, "datagram");
    final_report();
  end
endmodule
`default_nettype wire
